// >>> hdl/pir_fifo.sv
// Word FIFO with valid/ready on both sides and a synchronous clear
`timescale 1ns/1ns
module pir_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("pir_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;

  wire logic full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire logic empty = (wr_ptr_r == rd_ptr_r);
  wire logic push  = in_valid && !full;
  wire logic pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule

// >>> hdl/pir_pkg.sv
// Shared constants and types for the packet identify responder
package pir_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command and block geometry
  localparam logic [7:0] PIR_CMD_IDENTIFY = 8'ha1;
  localparam int         PIR_WORDS        = 256;
  localparam int         PIR_FIFO_DEPTH   = 8;
  localparam int         PIR_WORD_W       = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Word indices inside the identification block
  localparam logic [7:0] PIR_W_GENCFG    = 8'h00;
  localparam logic [7:0] PIR_W_SERIAL    = 8'h0a;
  localparam logic [7:0] PIR_W_SERIAL_E  = 8'h13;
  localparam logic [7:0] PIR_W_FWREV     = 8'h17;
  localparam logic [7:0] PIR_W_FWREV_E   = 8'h1a;
  localparam logic [7:0] PIR_W_MODEL     = 8'h1b;
  localparam logic [7:0] PIR_W_MODEL_E   = 8'h2e;
  localparam logic [7:0] PIR_W_CAPS      = 8'h31;
  localparam logic [7:0] PIR_W_PIOMODE   = 8'h33;
  localparam logic [7:0] PIR_W_VALID     = 8'h35;

  // String lengths in characters
  localparam int PIR_SERIAL_CH = 20;
  localparam int PIR_FWREV_CH  = 8;
  localparam int PIR_MODEL_CH  = 40;

  ////////////////////////////////////////////////////////////////////////////
  // Field codes of the general configuration word
  localparam logic [1:0] PIR_DEVTYPE_PACKET = 2'b10;
  localparam logic [1:0] PIR_DRQ_3MS        = 2'b00;
  localparam logic [1:0] PIR_DRQ_RSVD       = 2'b11;
  localparam logic [1:0] PIR_PKT_12B        = 2'b00;

  ////////////////////////////////////////////////////////////////////////////
  // Static configuration the device reports
  typedef struct packed {
    logic [4:0] cmd_set;
    logic       removable;
    logic [1:0] drq_type;
    logic [1:0] pkt_len;
    logic [7:0] caps;
    logic [7:0] vend_caps;
    logic [7:0] pio_mode;
    logic [7:0] vend_pio;
    logic [2:0] valid_flags;
  } pir_cfg_t;

  // Task-file status bits as the host sees them
  typedef struct packed {
    logic bsy;
    logic drdy;
    logic df;
    logic drq;
    logic err;
  } pir_status_t;

endpackage

// >>> hdl/pir_responder.sv
// Device-side identify packet device command engine with word data phase
// What this block does
// [RQ1] Identify command is accepted whatever the device-ready bit shows.
// [RQ2] On the command: set busy, build 256 words, set data request, clear busy.
// [RQ3] Interrupt request raised with data request only when interrupt disable is low.
// [RQ4] Host fetches the words by successive data register reads.
// [RQ5] All reserved bits and reserved words read back as zero.
// [RQ6] Bit-field words put bit n on data line n.
// [RQ7] Number words put the most significant bit on line 15.
// [RQ8] A 32-bit value goes low half first, then high half.
// [RQ9] Strings pack two characters per word, earlier character in high byte.
// [RQ10] Word 0 bits 15-14 report binary 10, the packet device type.
// [RQ11] Word 0 reports command packet set in bits 12-8, removable in bit 7.
// [RQ12] Word 0 bits 6-5 report data request timing; pattern 11 is reserved.
// [RQ13] Word 0 bits 1-0 report packet length; 1x patterns are reserved.
// [RQ14] Words 10 to 19 carry the twenty-character serial number.
// [RQ15] Words 23-26 carry firmware revision, words 27-46 the model name.
// [RQ16] Word 49 high byte reports capabilities, low byte vendor defined.
// [RQ17] Word 51 high byte reports the PIO mode, low byte vendor defined.
// [RQ18] Word 53 bits 2-0 flag validity of word 88, 64-70, 54-58.
// [RQ19] Normal end: busy, data request, fault, error clear; device ready set.
// [RQ20] Without the command: aborted-command error; with it: no error.
// [RQ21] After the last of 256 words is read, data request clears.
`timescale 1ns/1ns
module pir_responder
  import pir_pkg::*;
#(
  parameter bit                       IMPLEMENTED = 1'b1,
  parameter logic [8*PIR_SERIAL_CH-1:0] SERIAL_STR  = {PIR_SERIAL_CH{8'h20}},
  parameter logic [8*PIR_FWREV_CH-1:0]  FWREV_STR   = {PIR_FWREV_CH{8'h20}},
  parameter logic [8*PIR_MODEL_CH-1:0]  MODEL_STR   = {PIR_MODEL_CH{8'h20}},
  parameter int                       FIFO_DEPTH  = PIR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Command register write
  input  wire logic                  cmd_wr,
  input  wire logic [7:0]            cmd_code,
  // Control from the device control register
  input  wire logic                  int_dis,
  // Register reads by the host
  input  wire logic                  data_rd,
  input  wire logic                  status_rd,
  // Static identification content
  input  wire pir_pkg::pir_cfg_t     cfg,
  // Results toward the host
  output logic [PIR_WORD_W-1:0]      data_out,
  output pir_pkg::pir_status_t       status,
  output logic                       abort_err,
  output logic                       intrq
);

  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > PIR_WORDS) begin
      $error("pir_responder: FIFO_DEPTH out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word builder helpers

  // Pick word k of a packed string; the first character sits in the top byte
  function automatic logic [15:0] str_word(input logic [8*PIR_MODEL_CH-1:0] s,
                                           input int chars,
                                           input logic [7:0] k);
    int top;
    top = 8 * chars - 1 - 16 * int'(k);
    str_word = s[top -: 16]; // see [RQ9]
  endfunction

  // Reserved code points are never reported; fall back to the base code
  function automatic logic [1:0] drq_code(input logic [1:0] c);
    drq_code = (c == PIR_DRQ_RSVD) ? PIR_DRQ_3MS : c; // see [RQ12]
  endfunction

  function automatic logic [1:0] pkt_code(input logic [1:0] c);
    pkt_code = c[1] ? PIR_PKT_12B : c; // see [RQ13]
  endfunction

  // Half of a 32-bit value: index 0 gives bits 15:0, index 1 bits 31:16
  function automatic logic [15:0] half32(input logic [31:0] v, input logic upper);
    half32 = upper ? v[31:16] : v[15:0]; // see [RQ8]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Identification content for one word index
  logic [7:0]  gen_idx;
  logic [15:0] gen_word;

  wire logic [8*PIR_MODEL_CH-1:0] serial_ext = {{(8*(PIR_MODEL_CH-PIR_SERIAL_CH)){1'b0}},
                                                SERIAL_STR};
  wire logic [8*PIR_MODEL_CH-1:0] fwrev_ext  = {{(8*(PIR_MODEL_CH-PIR_FWREV_CH)){1'b0}},
                                                FWREV_STR};

  wire logic [15:0] w_gencfg = {PIR_DEVTYPE_PACKET,      // see [RQ10]
                                1'b0,                    // see [RQ5]
                                cfg.cmd_set,             // see [RQ11]
                                cfg.removable,           // see [RQ11]
                                drq_code(cfg.drq_type),  // see [RQ12]
                                3'h0,                    // see [RQ5]
                                pkt_code(cfg.pkt_len)};  // see [RQ13]

  wire logic [15:0] w_caps    = {cfg.caps, cfg.vend_caps};     // see [RQ16]
  wire logic [15:0] w_piomode = {cfg.pio_mode, cfg.vend_pio};  // see [RQ17] [RQ7]
  wire logic [15:0] w_valid   = {13'h0000, cfg.valid_flags};   // see [RQ18] [RQ6]

  wire logic in_serial = (gen_idx >= PIR_W_SERIAL) && (gen_idx <= PIR_W_SERIAL_E);
  wire logic in_fwrev  = (gen_idx >= PIR_W_FWREV)  && (gen_idx <= PIR_W_FWREV_E);
  wire logic in_model  = (gen_idx >= PIR_W_MODEL)  && (gen_idx <= PIR_W_MODEL_E);

  // Bit-field words keep bit n on data line n, numbers keep their MSB on line 15
  always_comb begin
    gen_word = 16'h0000; // see [RQ5]
    if (gen_idx == PIR_W_GENCFG) begin
      gen_word = w_gencfg; // see [RQ6]
    end else if (in_serial) begin
      gen_word = str_word(serial_ext, PIR_SERIAL_CH, gen_idx - PIR_W_SERIAL); // see [RQ14]
    end else if (in_fwrev) begin
      gen_word = str_word(fwrev_ext, PIR_FWREV_CH, gen_idx - PIR_W_FWREV); // see [RQ15]
    end else if (in_model) begin
      gen_word = str_word(MODEL_STR, PIR_MODEL_CH, gen_idx - PIR_W_MODEL); // see [RQ15]
    end else if (gen_idx == PIR_W_CAPS) begin
      gen_word = w_caps;
    end else if (gen_idx == PIR_W_PIOMODE) begin
      gen_word = w_piomode;
    end else if (gen_idx == PIR_W_VALID) begin
      gen_word = w_valid;
    end else if (gen_idx == 8'h39 || gen_idx == 8'h3a) begin
      // Words 57-58 form a 32-bit pair, reserved here and so held at zero
      gen_word = half32(32'h0000_0000, gen_idx[0] == 1'b0); // see [RQ8] [RQ5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  typedef enum logic [1:0] {
    PIR_ST_IDLE,
    PIR_ST_PREP,
    PIR_ST_DRQ,
    PIR_ST_XFER
  } pir_state_t;

  pir_state_t state_r;
  pir_state_t state_nxt;

  logic [8:0] gen_cnt_r;
  logic [8:0] rd_cnt_r;
  logic       hold_vld_r;
  logic [15:0] hold_r;
  logic       bsy_r;
  logic       drq_r;
  logic       drdy_r;
  logic       err_r;
  logic       abrt_r;
  logic       intrq_r;

  // A write while busy is ignored; while transferring an identify write restarts the block
  wire logic cmd_take   = cmd_wr && !bsy_r;
  wire logic identify   = cmd_take && (cmd_code == PIR_CMD_IDENTIFY); // see [RQ1]
  wire logic start      = identify && IMPLEMENTED;
  wire logic refuse     = identify && !IMPLEMENTED;                   // see [RQ20]

  wire logic gen_done   = gen_cnt_r == 9'(PIR_WORDS);
  wire logic fifo_in_vld;
  wire logic fifo_in_rdy;
  wire logic fifo_out_vld;
  wire logic fifo_out_rdy;
  wire logic [15:0] fifo_out_data;

  // The generator runs ahead of the host and stalls when the FIFO is full
  assign fifo_in_vld = (state_r != PIR_ST_IDLE) && !gen_done && !start;
  assign gen_idx     = gen_cnt_r[7:0];

  wire logic take      = (state_r == PIR_ST_XFER) && data_rd && hold_vld_r; // see [RQ4]
  wire logic last_take = take && (rd_cnt_r == 9'(PIR_WORDS - 1));           // see [RQ21]
  wire logic hold_load = fifo_out_vld && (!hold_vld_r || take) && !start;

  assign fifo_out_rdy = hold_load;

  // Data request waits until the output word and the FIFO are primed
  wire logic primed = hold_vld_r && (!fifo_in_rdy || gen_done);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PIR_ST_IDLE: begin
        if (start) state_nxt = PIR_ST_PREP;
      end
      PIR_ST_PREP: begin
        if (primed) state_nxt = PIR_ST_DRQ;
      end
      PIR_ST_DRQ: begin
        state_nxt = PIR_ST_XFER;
      end
      PIR_ST_XFER: begin
        if (start) begin
          state_nxt = PIR_ST_PREP;
        end else if (last_take) begin
          state_nxt = PIR_ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word buffer between generator and data register
  pir_fifo #(
    .WIDTH (PIR_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clear     (start),
    .in_valid  (fifo_in_vld),
    .in_ready  (fifo_in_rdy),
    .in_data   (gen_word),
    .out_valid (fifo_out_vld),
    .out_ready (fifo_out_rdy),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and counters
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= PIR_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || start) begin
      gen_cnt_r <= 9'h000;
    end else if (fifo_in_vld && fifo_in_rdy) begin
      gen_cnt_r <= gen_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || start) begin
      rd_cnt_r <= 9'h000;
    end else if (take) begin
      rd_cnt_r <= rd_cnt_r + 9'h001;
    end
  end

  // Output word register: data_out always shows the next word to be read
  always_ff @(posedge ref_clk) begin
    if (!rst_n || start) begin
      hold_vld_r <= 1'b0;
      hold_r     <= 16'h0000;
    end else if (hold_load) begin
      hold_vld_r <= 1'b1;
      hold_r     <= fifo_out_data;
    end else if (take) begin
      hold_vld_r <= 1'b0;
      hold_r     <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits
  wire logic enter_drq = (state_r == PIR_ST_PREP) && primed;
  wire logic enter_xfr = (state_r == PIR_ST_DRQ);

  // Busy rises with the command, data request one cycle before busy falls
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
    end else begin
      if (start) begin
        bsy_r <= 1'b1; // see [RQ2]
        drq_r <= 1'b0;
      end else begin
        if (enter_drq) drq_r <= 1'b1; // see [RQ2]
        if (enter_xfr) bsy_r <= 1'b0; // see [RQ2]
        if (last_take) drq_r <= 1'b0; // see [RQ21] [RQ19]
      end
    end
  end

  // Ready and error reflect the outcome of the most recent identify command
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drdy_r <= 1'b0;
      err_r  <= 1'b0;
      abrt_r <= 1'b0;
    end else if (start) begin
      err_r  <= 1'b0; // see [RQ20]
      abrt_r <= 1'b0;
    end else if (refuse) begin
      drdy_r <= 1'b1;
      err_r  <= 1'b1; // see [RQ20]
      abrt_r <= 1'b1;
    end else if (last_take) begin
      drdy_r <= 1'b1; // see [RQ19]
      err_r  <= 1'b0;
    end
  end

  // Interrupt pends until the host reads status, issues a new command or sets int_dis;
  // a new event in the same cycle as the status read wins
  wire logic int_event = (enter_xfr || refuse) && !int_dis; // see [RQ3]

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      intrq_r <= 1'b0;
    end else if (int_event) begin
      intrq_r <= 1'b1; // see [RQ3]
    end else if (status_rd || cmd_take || int_dis) begin
      intrq_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign data_out    = hold_r;
  assign status.bsy  = bsy_r;
  assign status.drdy = drdy_r;
  assign status.df   = 1'b0; // see [RQ19]
  assign status.drq  = drq_r;
  assign status.err  = err_r;
  assign abort_err   = abrt_r;
  assign intrq       = intrq_r;

endmodule

// >>> sim/pir_checker_sva.sv
// Concurrent checks on the identify responder ports
`timescale 1ns/1ns
module pir_checker_sva
  import pir_pkg::*;
#(
  parameter bit IMPLEMENTED = 1'b1
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Host requests and static identification content
  input  wire logic                  cmd_wr,
  input  wire logic [7:0]            cmd_code,
  input  wire logic                  int_dis,
  input  wire logic                  data_rd,
  input  wire logic                  status_rd,
  input  wire pir_pkg::pir_cfg_t     cfg,
  // Device answers
  input  wire logic [PIR_WORD_W-1:0] data_out,
  input  wire pir_pkg::pir_status_t  status,
  input  wire logic                  abort_err,
  input  wire logic                  intrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [8:0] rd_cnt_r;
  logic [8:0] rd_cnt_nxt;
  wire        rd_acc = data_rd && status.drq && !status.bsy;
  wire        id_acc = cmd_wr && (cmd_code == PIR_CMD_IDENTIFY) && !status.bsy;
  wire        rsvd_w = rd_cnt_r inside {[9'h001:9'h009], [9'h014:9'h016], 9'h02f, 9'h030,
                                        9'h032, 9'h034, [9'h036:9'h0ff]};

  // Index of the word on data_out at the moment a read is taken
  assign rd_cnt_nxt = id_acc ? 9'h000 : rd_cnt_r + {8'h00, rd_acc};
  always_ff @(posedge ref_clk) rd_cnt_r <= !rst_n ? 9'h000 : rd_cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  bsy_on_cmd_a: assert property (id_acc && IMPLEMENTED |=> status.bsy && !status.drq)
    else $error("busy not raised by identify");
  drq_lead_a: assert property ($fell(status.bsy) |-> status.drq && $past(status.drq))
    else $error("busy cleared without data request first");
  busy_bounded_a: assert property ($rose(status.bsy) |-> ##[1:40] !status.bsy)
    else $error("busy stuck");
  irq_ready_a: assert property ($fell(status.bsy) && !$past(int_dis) |-> intrq)
    else $error("interrupt missing at data ready");
  irq_masked_a: assert property (int_dis && $past(int_dis) |-> !intrq)
    else $error("interrupt raised while disabled");
  last_read_a: assert property (rd_acc && rd_cnt_r == 9'h0ff |=> !status.drq)
    else $error("data request held after last word");
  drq_count_a: assert property ($fell(status.drq) && !status.bsy |-> rd_cnt_r == 9'h100)
    else $error("data phase ended early");
  done_status_a: assert property ($fell(status.drq) && !status.bsy |->
    status.drdy && !status.err && !status.df && !abort_err)
    else $error("bad completion status");
  reserved_zero_a: assert property (rd_acc && rsvd_w |-> data_out == 16'h0000)
    else $error("reserved word not zero");
  word_zero_a: assert property (rd_acc && rd_cnt_r == 9'h000 |-> data_out[15:13] == 3'b100
    && data_out[12:7] == {cfg.cmd_set, cfg.removable} && data_out[4:2] == 3'b000)
    else $error("general configuration word wrong");
  caps_word_a: assert property (rd_acc && rd_cnt_r == 9'h031 |->
    data_out == {cfg.caps, cfg.vend_caps})
    else $error("capabilities word wrong");
endmodule

bind pir_responder pir_checker_sva #(.IMPLEMENTED(IMPLEMENTED)) pir_checker_sva_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
  .int_dis(int_dis), .data_rd(data_rd), .status_rd(status_rd), .cfg(cfg),
  .data_out(data_out), .status(status), .abort_err(abort_err), .intrq(intrq));

// >>> sim/pir_host_model.sv
// Host adapter model that pulls identification words through the data register
`timescale 1ns/1ns
module pir_host_model
  import pir_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Idle cycles between reads beyond the one always left, chosen by the bench
  input  wire logic [3:0]            gap,
  // Device side
  input  wire pir_pkg::pir_status_t  status,
  input  wire logic [PIR_WORD_W-1:0] data_in,
  output logic                       data_rd,
  // Words as captured
  output logic                       word_stb,
  output logic [7:0]                 word_idx,
  output logic [PIR_WORD_W-1:0]      word_out
);
  logic [3:0] wait_r;
  logic [8:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Busy restarts the count; reads always leave one idle cycle so none is dropped
  always @(posedge ref_clk) begin
    word_stb <= 1'b0;
    if (!rst_n || status.bsy) begin
      data_rd <= 1'b0;
      wait_r  <= 4'h0;
      cnt_r   <= 9'h000;
    end else if (data_rd) begin
      data_rd  <= 1'b0;
      wait_r   <= gap;
      word_stb <= 1'b1;
      word_out <= data_in;
      word_idx <= cnt_r[7:0];
      cnt_r    <= cnt_r + 9'h001;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (status.drq) begin
      data_rd <= 1'b1;
    end
  end
endmodule

// >>> sim/test_packet_identify_responder.sv
// Self-checking bench for the identify responder
`timescale 1ns/1ns
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module test_packet_identify_responder;
  import pir_pkg::*;
  localparam logic [159:0] SER = {2{"SN01234567"}};
  localparam logic [63:0]  FWR = "FWREV1.0";
  localparam logic [319:0] MOD = {4{"ModelName-"}};

  logic                  ref_clk, rst_n, cmd_wr, int_dis, status_rd, data_rd;
  logic                  word_stb, abort_err, intrq;
  logic [7:0]            cmd_code, word_idx;
  logic [3:0]            gap;
  logic [PIR_WORD_W-1:0] data_out, word_out;
  pir_cfg_t              cfg;
  pir_status_t           status;
  int                    n_errors, tests_run, n_words, cycles;

  pir_responder #(.SERIAL_STR(SER), .FWREV_STR(FWR), .MODEL_STR(MOD)) pir_responder_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .int_dis(int_dis), .data_rd(data_rd), .status_rd(status_rd), .cfg(cfg),
    .data_out(data_out), .status(status), .abort_err(abort_err), .intrq(intrq));

  pir_host_model pir_host_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .gap(gap), .status(status), .data_in(data_out),
    .data_rd(data_rd), .word_stb(word_stb), .word_idx(word_idx), .word_out(word_out));

  ////////////////////////////////////////////////////////////////////////////
  // Reserved codes in word 0 are reported as the plain defaults
  function automatic logic [15:0] exp_word(input logic [7:0] k);
    logic [15:0] w;
    w = 16'h0000;
    if (k == PIR_W_GENCFG)
      w = {2'b10, 1'b0, cfg.cmd_set, cfg.removable,
           (cfg.drq_type == 2'b11) ? 2'b00 : cfg.drq_type, 3'b000,
           cfg.pkt_len[1] ? 2'b00 : cfg.pkt_len};
    if (k >= PIR_W_SERIAL && k <= PIR_W_SERIAL_E) w = SER[159 - 16 * (k - PIR_W_SERIAL) -: 16];
    if (k >= PIR_W_FWREV && k <= PIR_W_FWREV_E) w = FWR[63 - 16 * (k - PIR_W_FWREV) -: 16];
    if (k >= PIR_W_MODEL && k <= PIR_W_MODEL_E) w = MOD[319 - 16 * (k - PIR_W_MODEL) -: 16];
    if (k == PIR_W_CAPS) w = {cfg.caps, cfg.vend_caps};
    if (k == PIR_W_PIOMODE) w = {cfg.pio_mode, cfg.vend_pio};
    if (k == PIR_W_VALID) w = {13'h0000, cfg.valid_flags};
    return w;
  endfunction

  task close_out;
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task tick;
    @(posedge ref_clk);
    #1;
  endtask

  task send_cmd(input logic [7:0] code);
    tick();
    cmd_wr   = 1'b1;
    cmd_code = code;
    tick();
    cmd_wr = 1'b0;
  endtask

  // One whole identify: command, ready handshake, 256 reads, completion
  task identify(input logic dis, input logic [3:0] g);
    int i;
    int_dis = dis;
    gap     = g;
    n_words = 0;
    send_cmd(PIR_CMD_IDENTIFY);
    `CHECK(status.bsy, 1'b1)
    i = 0;
    while (status.drq !== 1'b1 && i < 50) begin
      tick();
      i++;
    end
    `CHECK(status.bsy, 1'b1)
    tick();
    `CHECK(status.bsy, 1'b0)
    `CHECK(intrq, ~dis)
    status_rd = 1'b1;
    tick();
    status_rd = 1'b0;
    `CHECK(intrq, 1'b0)
    i = 0;
    while (status.drq !== 1'b0 && i < 5000) begin
      tick();
      i++;
    end
    tick();
    `CHECK(status, 5'h08)
    `CHECK(abort_err, 1'b0)
    `CHECK(data_out, 16'h0000)
    `CHECK(n_words, 256)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) if (word_stb === 1'b1) begin
    n_words++;
    `CHECK(word_out, exp_word(word_idx))
  end

  // The whole run is about 4200 cycles; the ceiling leaves ample room
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0; cmd_wr = 1'b0; cmd_code = 8'h00; int_dis = 1'b0; status_rd = 1'b0;
    gap = 4'h0; n_errors = 0; tests_run = 0; cycles = 0; n_words = 0;
    cfg = '{5'h05, 1'b1, 2'b10, 2'b01, 8'ha5, 8'h3c, 8'h04, 8'h81, 3'b101};
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    `CHECK(status, 5'h00)
    `CHECK(data_out, 16'h0000)
    // Another opcode must leave the device idle
    send_cmd(8'hec);
    `CHECK(status.bsy, 1'b0)
    // First identify runs with device-ready still low
    identify(1'b0, 4'h0);
    cfg = '{5'h1f, 1'b0, 2'b11, 2'b11, 8'h5a, 8'hc3, 8'h02, 8'h7e, 3'b010};
    identify(1'b1, 4'h5);
    cfg = '{5'h0a, 1'b1, 2'b01, 2'b10, 8'hff, 8'h00, 8'h03, 8'h55, 3'b100};
    identify(1'b0, 4'h2);
    cfg = '{5'h00, 1'b0, 2'b00, 2'b00, 8'h81, 8'hff, 8'h01, 8'haa, 3'b011};
    identify(1'b0, 4'h1);
    close_out();
  end
endmodule
